// file: rftxc_params.svh
// register offsets, field positions, reset values and timing counts
// for the transmitter driver and transmit check configuration bank.
// assumes inclusion by bare name from the design file only.
`ifndef RFTXC_PARAMS_SVH
`define RFTXC_PARAMS_SVH

`define RFTXC_OFS_DRIVER_PIN_CONTROL     8'h28
`define RFTXC_OFS_CARRIER_AMPLITUDE      8'h29
`define RFTXC_OFS_MODULATION_CONTROL     8'h2A
`define RFTXC_OFS_LOAD_CURRENT_OVERSHOOT 8'h2B
`define RFTXC_OFS_TX_CHECK_CONFIG        8'h2C

`define RFTXC_RST_DRIVER_PIN_CONTROL     8'h00
`define RFTXC_RST_CARRIER_AMPLITUDE      8'h00
`define RFTXC_RST_MODULATION_CONTROL     8'h00
`define RFTXC_RST_LOAD_CURRENT_OVERSHOOT 8'h00
`define RFTXC_RST_TX_CHECK_CONFIG        8'h00

// writable bits of each register; reserved bits read as zero
`define RFTXC_MSK_DRIVER_PIN_CONTROL     8'hCF
`define RFTXC_MSK_CARRIER_AMPLITUDE      8'hDF
`define RFTXC_MSK_MODULATION_CONTROL     8'hFF
`define RFTXC_MSK_LOAD_CURRENT_OVERSHOOT 8'hFF
`define RFTXC_MSK_TX_CHECK_CONFIG        8'h7F

`define RFTXC_BIT_SECOND_INV   7
`define RFTXC_BIT_FIRST_INV    6
`define RFTXC_BIT_OUTPUTS_ON   3
`define RFTXC_BIT_CW_MAX       3
`define RFTXC_BIT_MOD_INVERT   2
`define RFTXC_BIT_CHECK_INVERT 1
`define RFTXC_BIT_CHECK_APPEND 0

// fixed check presets
`define RFTXC_P16_0 16'h0000
`define RFTXC_P16_1 16'h6363
`define RFTXC_P16_2 16'hA671
`define RFTXC_P16_3 16'hFFFE
`define RFTXC_P16_7 16'hFFFF
`define RFTXC_P8_0  8'h00
`define RFTXC_P8_1  8'h12
`define RFTXC_P8_2  8'hBF
`define RFTXC_P8_3  8'hFD
`define RFTXC_P8_7  8'hFF
`define RFTXC_P5_0  5'h00
`define RFTXC_P5_1  5'h12
`define RFTXC_P5_7  5'h1F

// system clock cycles per carrier half period
`define RFTXC_CARRIER_HALF_DIV 4

`endif

// file: rftxc_pkg.sv
// types shared by the transmitter configuration bank.
// assumes nothing of its surroundings.
package rftxc_pkg;

    typedef enum logic [1:0] {
        RFTXC_CHK5  = 2'h0,
        RFTXC_CHK8  = 2'h1,
        RFTXC_CHK16 = 2'h2,
        RFTXC_CHKRS = 2'h3
    } rftxc_kind_type;

    typedef enum logic [1:0] {
        RFTXC_SRC_NONE = 2'h0,
        RFTXC_SRC_ENV  = 2'h1,
        RFTXC_SRC_EXT  = 2'h2,
        RFTXC_SRC_RSV  = 2'h3
    } rftxc_src_type;

    typedef enum logic [2:0] {
        RFTXC_DRV_HIZ  = 3'h0,
        RFTXC_DRV_LOW  = 3'h1,
        RFTXC_DRV_HIGH = 3'h2,
        RFTXC_DRV_BAD3 = 3'h3,
        RFTXC_DRV_PP   = 3'h4,
        RFTXC_DRV_OD   = 3'h5,
        RFTXC_DRV_BAD6 = 3'h6,
        RFTXC_DRV_PPX  = 3'h7
    } rftxc_style_type;

    // gray codes along idle -> data -> check
    typedef enum logic [1:0] {
        RFTXC_ST_IDLE  = 2'b00,
        RFTXC_ST_DATA  = 2'b01,
        RFTXC_ST_CHECK = 2'b11
    } rftxc_state_type;

endpackage

// file: rftxc_bank.sv
// transmitter driver configuration bank with transmit check generator.
// assumes a byte-wide register port on clk and a bit stream source
// and sink on clk; the external modulation input is asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "rftxc_params.svh"

module rftxc_bank #(
    parameter int         CARRIER_HALF_DIV = `RFTXC_CARRIER_HALF_DIV,
    parameter logic [15:0] POLY16          = 16'h1021,
    parameter logic [7:0]  POLY8           = 8'h1D,
    parameter logic [4:0]  POLY5           = 5'h09
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic      [7:0]  reg_rdata,
    input  wire logic [15:0] user_preset_16,
    input  wire logic [7:0]  user_preset_8,
    input  wire logic [4:0]  user_preset_5,
    input  wire logic        internal_envelope,
    input  wire logic        external_signal_input,
    input  wire logic        in_valid,
    input  wire logic        in_bit,
    input  wire logic        in_last,
    output logic             in_ready,
    output logic             out_valid,
    output logic             out_bit,
    output logic             out_last,
    input  wire logic        out_ready,
    output logic             antenna_out_a,
    output logic             antenna_out_a_oe,
    output logic             antenna_out_b,
    output logic             antenna_out_b_oe,
    output logic      [1:0]  carrier_level_reduction,
    output logic             carrier_max,
    output logic      [4:0]  residual_carrier,
    output logic      [3:0]  load_current_trim,
    output logic             modulation_on,
    output logic             overshoot_pulse
);

    logic [1:0] rst_sync_ff;
    logic       rst_n;
    logic [7:0] drv_ff;
    logic [7:0] amp_ff;
    logic [7:0] mod_ff;
    logic [7:0] load_ff;
    logic [7:0] chk_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // register port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_ff  <= `RFTXC_RST_DRIVER_PIN_CONTROL;
            amp_ff  <= `RFTXC_RST_CARRIER_AMPLITUDE;
            mod_ff  <= `RFTXC_RST_MODULATION_CONTROL;
            load_ff <= `RFTXC_RST_LOAD_CURRENT_OVERSHOOT;
            chk_ff  <= `RFTXC_RST_TX_CHECK_CONFIG;
        end else if (reg_we) begin
            case (reg_addr)
                `RFTXC_OFS_DRIVER_PIN_CONTROL: begin
                    drv_ff <= reg_wdata & `RFTXC_MSK_DRIVER_PIN_CONTROL;
                end
                `RFTXC_OFS_CARRIER_AMPLITUDE: begin
                    amp_ff <= reg_wdata & `RFTXC_MSK_CARRIER_AMPLITUDE;
                end
                `RFTXC_OFS_MODULATION_CONTROL: begin
                    mod_ff <= reg_wdata & `RFTXC_MSK_MODULATION_CONTROL;
                end
                `RFTXC_OFS_LOAD_CURRENT_OVERSHOOT: begin
                    load_ff <= reg_wdata
                             & `RFTXC_MSK_LOAD_CURRENT_OVERSHOOT;
                end
                `RFTXC_OFS_TX_CHECK_CONFIG: begin
                    chk_ff <= reg_wdata & `RFTXC_MSK_TX_CHECK_CONFIG;
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (reg_addr)
            `RFTXC_OFS_DRIVER_PIN_CONTROL:     nxt_rdata = drv_ff;
            `RFTXC_OFS_CARRIER_AMPLITUDE:      nxt_rdata = amp_ff;
            `RFTXC_OFS_MODULATION_CONTROL:     nxt_rdata = mod_ff;
            `RFTXC_OFS_LOAD_CURRENT_OVERSHOOT: nxt_rdata = load_ff;
            `RFTXC_OFS_TX_CHECK_CONFIG:        nxt_rdata = chk_ff;
            default:                           nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_re) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    // analog settings, registered for a clean handover
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carrier_level_reduction <= 2'h0;
            carrier_max             <= 1'b0;
            residual_carrier        <= 5'h00;
            load_current_trim       <= 4'h0;
        end else begin
            carrier_max <= mod_ff[`RFTXC_BIT_CW_MAX];
            // reduction is forced to zero while maximum is set
            carrier_level_reduction <= mod_ff[`RFTXC_BIT_CW_MAX]
                                     ? 2'h0 : amp_ff[7:6];
            residual_carrier  <= amp_ff[4:0];
            load_current_trim <= load_ff[3:0];
        end
    end

    // carrier divider: one enable per half period
    localparam int DIVW = $clog2(CARRIER_HALF_DIV + 1);
    logic [DIVW-1:0] div_ff;
    logic            half_tick;
    logic            carrier_ff;
    logic            carrier_tick;

    assign half_tick = (div_ff == DIVW'(CARRIER_HALF_DIV - 1));
    assign carrier_tick = half_tick && !carrier_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff     <= '0;
            carrier_ff <= 1'b0;
        end else if (half_tick) begin
            div_ff     <= '0;
            carrier_ff <= !carrier_ff;
        end else begin
            div_ff <= div_ff + DIVW'(1);
        end
    end

    // modulation source
    logic [1:0] ext_sync_ff;
    logic       mod_sel;
    logic       mod_sig;
    logic       mod_prev_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync_ff <= 2'b00;
        end else begin
            ext_sync_ff <= {ext_sync_ff[0], external_signal_input};
        end
    end

    always_comb begin
        case (rftxc_pkg::rftxc_src_type'(mod_ff[1:0]))
            rftxc_pkg::RFTXC_SRC_ENV: mod_sel = internal_envelope;
            rftxc_pkg::RFTXC_SRC_EXT: mod_sel = ext_sync_ff[1];
            default:                  mod_sel = 1'b0;
        endcase
    end
    assign mod_sig = mod_sel ^ mod_ff[`RFTXC_BIT_MOD_INVERT];

    // overshoot: wait first value, then extra pulse, in carrier cycles
    logic [3:0] os_wait_ff;
    logic [3:0] os_len_ff;
    logic       os_arm_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_prev_ff     <= 1'b0;
            modulation_on   <= 1'b0;
            os_wait_ff      <= 4'h0;
            os_len_ff       <= 4'h0;
            os_arm_ff       <= 1'b0;
            overshoot_pulse <= 1'b0;
        end else begin
            mod_prev_ff   <= mod_sig;
            modulation_on <= mod_sig;
            if (mod_sig && !mod_prev_ff) begin
                os_wait_ff <= load_ff[7:4];
                os_len_ff  <= mod_ff[7:4];
                os_arm_ff  <= 1'b1;
            end else if (carrier_tick && os_arm_ff) begin
                if (os_wait_ff != 4'h0) begin
                    os_wait_ff <= os_wait_ff - 4'h1;
                end else if (os_len_ff != 4'h0) begin
                    os_len_ff <= os_len_ff - 4'h1;
                end else begin
                    os_arm_ff <= 1'b0;
                end
            end
            overshoot_pulse <= os_arm_ff && (os_wait_ff == 4'h0)
                             && (os_len_ff != 4'h0);
        end
    end

    // driver style decode, used for both pins; returns {level, enable}
    function automatic logic [1:0] drive(input logic [2:0] style,
                                         input logic       on,
                                         input logic       v);
        logic [1:0] r;
        r = 2'b00;
        if (on) begin
            case (rftxc_pkg::rftxc_style_type'(style))
                rftxc_pkg::RFTXC_DRV_LOW:  r = 2'b01;
                rftxc_pkg::RFTXC_DRV_HIGH: r = 2'b11;
                rftxc_pkg::RFTXC_DRV_PP:   r = {v, 1'b1};
                rftxc_pkg::RFTXC_DRV_PPX:  r = {v, 1'b1};
                rftxc_pkg::RFTXC_DRV_OD:   r = {1'b0, !v};
                // unsupported codes float the pin as the safe choice
                default:                   r = 2'b00;
            endcase
        end
        return r;
    endfunction

    logic [1:0] pin_a;
    logic [1:0] pin_b;

    assign pin_a = drive(drv_ff[2:0], drv_ff[`RFTXC_BIT_OUTPUTS_ON],
                         carrier_ff ^ drv_ff[`RFTXC_BIT_FIRST_INV]);
    assign pin_b = drive(drv_ff[2:0], drv_ff[`RFTXC_BIT_OUTPUTS_ON],
                         carrier_ff ^ drv_ff[`RFTXC_BIT_SECOND_INV]);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            antenna_out_a    <= 1'b0;
            antenna_out_a_oe <= 1'b0;
            antenna_out_b    <= 1'b0;
            antenna_out_b_oe <= 1'b0;
        end else begin
            {antenna_out_a, antenna_out_a_oe} <= pin_a;
            {antenna_out_b, antenna_out_b_oe} <= pin_b;
        end
    end

    // transmit check generator
    rftxc_pkg::rftxc_kind_type kind;
    rftxc_pkg::rftxc_state_type state_ff;
    logic [15:0] crc_ff;
    logic [15:0] preset;
    logic [4:0]  cnt_ff;
    logic [3:0]  top;
    logic        take;
    logic        sink_free;
    logic        chk_bit;

    assign kind = rftxc_pkg::rftxc_kind_type'(chk_ff[3:2]);

    always_comb begin
        case (kind)
            rftxc_pkg::RFTXC_CHK16: top = 4'hF;
            rftxc_pkg::RFTXC_CHK8:  top = 4'h7;
            default:                top = 4'h4;
        endcase
    end

    // codes four and five, and two/three with five bits, load zero
    always_comb begin
        preset = 16'h0000;
        case (kind)
            rftxc_pkg::RFTXC_CHK16: begin
                case (chk_ff[6:4])
                    3'h1:    preset = `RFTXC_P16_1;
                    3'h2:    preset = `RFTXC_P16_2;
                    3'h3:    preset = `RFTXC_P16_3;
                    3'h6:    preset = user_preset_16;
                    3'h7:    preset = `RFTXC_P16_7;
                    default: preset = `RFTXC_P16_0;
                endcase
            end
            rftxc_pkg::RFTXC_CHK8: begin
                case (chk_ff[6:4])
                    3'h1:    preset = {8'h00, `RFTXC_P8_1};
                    3'h2:    preset = {8'h00, `RFTXC_P8_2};
                    3'h3:    preset = {8'h00, `RFTXC_P8_3};
                    3'h6:    preset = {8'h00, user_preset_8};
                    3'h7:    preset = {8'h00, `RFTXC_P8_7};
                    default: preset = {8'h00, `RFTXC_P8_0};
                endcase
            end
            default: begin
                case (chk_ff[6:4])
                    3'h1:    preset = {11'h000, `RFTXC_P5_1};
                    3'h6:    preset = {11'h000, user_preset_5};
                    3'h7:    preset = {11'h000, `RFTXC_P5_7};
                    default: preset = {11'h000, `RFTXC_P5_0};
                endcase
            end
        endcase
    end

    // one shift of a msb-first generator; bits above the width stay zero
    function automatic logic [15:0] step(input logic [15:0] c,
                                         input logic [3:0]  t,
                                         input logic        b);
        logic [15:0] poly;
        logic [15:0] mask;
        logic        fb;
        poly = (t == 4'hF) ? POLY16
             : (t == 4'h7) ? {8'h00, POLY8} : {11'h000, POLY5};
        mask = (t == 4'hF) ? 16'hFFFF : (t == 4'h7) ? 16'h00FF : 16'h001F;
        fb   = b ^ c[t];
        return ((c << 1) & mask) ^ (fb ? poly : 16'h0000);
    endfunction

    assign sink_free = !out_valid || out_ready;
    assign in_ready  = sink_free && (state_ff != rftxc_pkg::RFTXC_ST_CHECK);
    assign take      = in_valid && in_ready;
    assign chk_bit   = crc_ff[top] ^ chk_ff[`RFTXC_BIT_CHECK_INVERT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= rftxc_pkg::RFTXC_ST_IDLE;
            crc_ff    <= 16'h0000;
            cnt_ff    <= 5'h00;
            out_valid <= 1'b0;
            out_bit   <= 1'b0;
            out_last  <= 1'b0;
        end else begin
            if (out_valid && out_ready) begin
                out_valid <= 1'b0;
            end
            case (state_ff)
                rftxc_pkg::RFTXC_ST_IDLE, rftxc_pkg::RFTXC_ST_DATA: begin
                    if (take) begin
                        crc_ff <= step((state_ff == rftxc_pkg::RFTXC_ST_IDLE)
                                       ? preset : crc_ff, top, in_bit);
                        out_valid <= 1'b1;
                        out_bit   <= in_bit;
                        if (in_last && chk_ff[`RFTXC_BIT_CHECK_APPEND]) begin
                            out_last <= 1'b0;
                            cnt_ff   <= {1'b0, top};
                            state_ff <= rftxc_pkg::RFTXC_ST_CHECK;
                        end else if (in_last) begin
                            out_last <= 1'b1;
                            state_ff <= rftxc_pkg::RFTXC_ST_IDLE;
                        end else begin
                            out_last <= 1'b0;
                            state_ff <= rftxc_pkg::RFTXC_ST_DATA;
                        end
                    end
                end
                rftxc_pkg::RFTXC_ST_CHECK: begin
                    if (sink_free) begin
                        out_valid <= 1'b1;
                        out_bit   <= chk_bit;
                        out_last  <= (cnt_ff == 5'h00);
                        crc_ff    <= crc_ff << 1;
                        cnt_ff    <= cnt_ff - 5'h01;
                        if (cnt_ff == 5'h00) begin
                            state_ff <= rftxc_pkg::RFTXC_ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff <= rftxc_pkg::RFTXC_ST_IDLE;
                end
            endcase
        end
    end

endmodule // rftxc_bank
`default_nettype wire

// file: rftxc_monitor.sv
// port-level checker for rftxc_bank.
// assumes one clk domain; bound below.
`timescale 1ns/10ps
`default_nettype none
module rftxc_monitor (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_we,
    input wire logic       reg_re,
    input wire logic [7:0] reg_rdata,
    input wire logic       in_valid,
    input wire logic       in_bit,
    input wire logic       in_last,
    input wire logic       in_ready,
    input wire logic       out_valid,
    input wire logic       out_bit,
    input wire logic       out_last,
    input wire logic       out_ready,
    input wire logic       antenna_out_a,
    input wire logic       antenna_out_a_oe,
    input wire logic       antenna_out_b,
    input wire logic       antenna_out_b_oe,
    input wire logic [1:0] carrier_level_reduction,
    input wire logic       carrier_max,
    input wire logic [4:0] residual_carrier,
    input wire logic [3:0] load_current_trim
);
    logic [7:0] drv_ff, amp_ff, mod_ff, ld_ff, chk_ff;
    // shadows keep reserved bits clear, as the bank does
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drv_ff <= 8'h00;
            amp_ff <= 8'h00;
            mod_ff <= 8'h00;
            ld_ff  <= 8'h00;
            chk_ff <= 8'h00;
        end else if (reg_we) begin
            case (reg_addr)
                8'h28: drv_ff <= reg_wdata & 8'hCF;
                8'h29: amp_ff <= reg_wdata & 8'hDF;
                8'h2A: mod_ff <= reg_wdata;
                8'h2B: ld_ff  <= reg_wdata;
                8'h2C: chk_ff <= reg_wdata & 8'h7F;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_last_in;
        in_valid && in_ready && in_last;
    endsequence
    sequence s_stall;
        out_valid && !out_ready;
    endsequence
    AST_PIN_INV: assert property (
        $past(drv_ff[3:0]) == 4'hC |-> (antenna_out_a ^ antenna_out_b)
        == $past(drv_ff[7] ^ drv_ff[6])) else $error("pin invert wrong");
    AST_OE_OFF: assert property (
        !$past(drv_ff[3]) |-> !antenna_out_a_oe && !antenna_out_b_oe)
        else $error("pins driven while off");
    AST_PP_ON: assert property (
        $past(drv_ff[3:0]) == 4'hC |-> antenna_out_a_oe && antenna_out_b_oe)
        else $error("pins not driven");
    AST_LEVEL: assert property (
        carrier_level_reduction == ($past(mod_ff[3]) ? 2'h0
        : $past(amp_ff[7:6]))) else $error("level wrong");
    AST_CWMAX: assert property (
        carrier_max == $past(mod_ff[3])) else $error("carrier max wrong");
    AST_RESIDUAL: assert property (
        residual_carrier == $past(amp_ff[4:0])) else $error("residual wrong");
    AST_TRIM: assert property (
        load_current_trim == $past(ld_ff[3:0])) else $error("trim wrong");
    AST_CHK_READ: assert property (
        reg_re && reg_addr == 8'h2C |=> reg_rdata == $past(chk_ff))
        else $error("check read wrong");
    AST_APPEND_GAP: assert property (
        s_last_in ##0 chk_ff[0] |=> !in_ready ##0 out_valid && !out_last)
        else $error("no check after last");
    AST_NO_APPEND: assert property (
        s_last_in ##0 !chk_ff[0] |=> out_valid && out_last)
        else $error("frame not closed");
    AST_PASS: assert property (
        in_valid && in_ready |=> out_valid && out_bit == $past(in_bit))
        else $error("data bit not passed");
    AST_HOLD: assert property (
        s_stall |=> out_valid && $stable(out_bit) && $stable(out_last))
        else $error("changed while stalled");
endmodule // rftxc_monitor
bind rftxc_bank rftxc_monitor i_mon (.*);
`default_nettype wire

// file: rftxc_sink.sv
// modulator-side stream sink model.
// assumes the bank's stream on the same clock.
`timescale 1ns/10ps
`default_nettype none
module rftxc_sink (
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        stall,
    input  wire logic        out_valid,
    input  wire logic        out_bit,
    input  wire logic        out_last,
    output logic             out_ready,
    output logic      [31:0] rx_bits,
    output logic      [7:0]  rx_cnt,
    output logic             rx_done
);
    // stalls every other cycle so held outputs get exercised
    always_ff @(posedge clk) begin
        out_ready <= clr | (stall ? !out_ready : 1'b1);
    end
    always_ff @(posedge clk) begin
        if (clr) begin
            rx_bits <= 32'h0;
            rx_cnt  <= 8'h00;
            rx_done <= 1'b0;
        end else if (out_valid && out_ready && !rx_done) begin
            rx_bits <= {rx_bits[30:0], out_bit};
            rx_cnt  <= rx_cnt + 8'h01;
            rx_done <= out_last;
        end
    end
endmodule // rftxc_sink
`default_nettype wire

// file: tb_top.sv
// self-checking bench for rftxc_bank.
// assumes sink model and checker compiled with it.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [15:0] P16 = 16'h1021;
    localparam logic [7:0]  P8 = 8'h1D;
    localparam logic [4:0]  P5 = 5'h09;
    localparam logic [7:0]  FRAME = 8'hB2;
    logic clk, arst_n, reg_we, reg_re, in_valid, in_bit, in_last, clr;
    logic stall, out_ready, internal_envelope, external_signal_input;
    logic in_ready, out_valid, out_bit, out_last, carrier_max, rx_done;
    logic antenna_out_a, antenna_out_a_oe, antenna_out_b, antenna_out_b_oe;
    logic modulation_on, overshoot_pulse, inv, ap;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, user_preset_8, d, rx_cnt;
    logic [15:0] user_preset_16, p, m;
    logic [4:0]  user_preset_5, residual_carrier;
    logic [3:0]  load_current_trim;
    logic [1:0]  carrier_level_reduction, k;
    logic [2:0]  code;
    logic [31:0] rx_bits;
    int          n_mismatch, compares, w;
    logic [23:0] reg_rows [7] = '{24'h28FFCF, 24'h29FFDF, 24'h2AFFFF,
        24'h2BFFFF, 24'h2CFF7F, 24'h2DFF00, 24'h27FF00};
    logic [10:0] mod_rows [6] = '{11'h00F, 11'h02C, 11'h006, 11'h013,
        11'h032, 11'h01E};
    logic [7:0]  drv_rows [6] = '{8'h4C, 8'h8C, 8'hCC, 8'h04, 8'h09, 8'h0A};
    // kind, code, inv, append, preset; codes 4, 5 unused
    logic [22:0] ck_rows [12] = '{{2'h0, 3'h1, 2'h2, 16'h0012},
        {2'h0, 3'h7, 2'h3, 16'h001F}, {2'h0, 3'h6, 2'h1, 16'h000B},
        {2'h1, 3'h2, 2'h3, 16'h00BF}, {2'h1, 3'h3, 2'h0, 16'h00FD},
        {2'h1, 3'h6, 2'h1, 16'h003C}, {2'h2, 3'h1, 2'h1, 16'h6363},
        {2'h2, 3'h2, 2'h1, 16'hA671}, {2'h2, 3'h3, 2'h3, 16'hFFFE},
        {2'h2, 3'h7, 2'h1, 16'hFFFF}, {2'h2, 3'h6, 2'h1, 16'h5AC3},
        {2'h2, 3'h0, 2'h1, 16'h0000}};
    rftxc_bank i_dut (
        .clk, .arst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .user_preset_16, .user_preset_8, .user_preset_5, .internal_envelope,
        .external_signal_input, .in_valid, .in_bit, .in_last, .in_ready,
        .out_valid, .out_bit, .out_last, .out_ready, .antenna_out_a,
        .antenna_out_a_oe, .antenna_out_b, .antenna_out_b_oe,
        .carrier_level_reduction, .carrier_max, .residual_carrier,
        .load_current_trim, .modulation_on, .overshoot_pulse);
    rftxc_sink i_sink (.clk, .clr, .stall, .out_valid, .out_bit,
        .out_last, .out_ready, .rx_bits, .rx_cnt, .rx_done);
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge clk) #1;
        reg_addr = a;
        reg_wdata = v;
        reg_we = 1'b1;
        @(posedge clk) #1;
        reg_we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk) #1;
        reg_addr = a;
        reg_re = 1'b1;
        @(posedge clk) #1;
        reg_re = 1'b0;
        d = reg_rdata;
    endtask
    function automatic logic [15:0] crc_of();
        logic [15:0] c;
        logic [15:0] poly;
        poly = k == 2'h2 ? P16 : k == 2'h1 ? {8'h00, P8} : {11'h0, P5};
        c = p;
        for (int i = 7; i >= 0; i--)
            c = ({c[14:0], 1'b0} & m) ^ ((FRAME[i] ^ c[w-1]) ? poly : 16'h0);
        return c;
    endfunction
    task automatic send_frame();
        logic rdy;
        for (int i = 7; i >= 0; i--) begin
            in_valid = 1'b1;
            in_bit = FRAME[i];
            in_last = (i == 0);
            do begin
                @(negedge clk) rdy = in_ready;
                @(posedge clk) #1;
            end while (!rdy);
        end
        in_valid = 1'b0;
        in_last = 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        n_mismatch++;
        results();
    end
    initial begin
        {arst_n, reg_we, reg_re, in_valid, in_bit, in_last, clr, stall} = 0;
        {internal_envelope, external_signal_input, reg_addr, reg_wdata} = 0;
        user_preset_16 = 16'h5AC3;
        user_preset_8 = 8'h3C;
        user_preset_5 = 5'h0B;
        repeat (5) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (2) @(posedge clk) #1;
        chk("oe_rst", antenna_out_a_oe, 1'b0);
        for (int a = 8'h28; a <= 8'h2C; a++) begin
            rd(a[7:0]);
            chk("rst_val", d, 8'h00);
        end
        foreach (reg_rows[r]) begin
            wr(reg_rows[r][23:16], reg_rows[r][15:8]);
            rd(reg_rows[r][23:16]);
            chk("reg", d, reg_rows[r][7:0]);
        end
        wr(8'h29, 8'hC5);
        wr(8'h2B, 8'hA7);
        wr(8'h2A, 8'h08);
        repeat (3) @(posedge clk) #1;
        chk("level_max", carrier_level_reduction, 2'h0);
        chk("residual", residual_carrier, 5'h05);
        chk("trim", load_current_trim, 4'h7);
        wr(8'h2A, 8'h00);
        repeat (3) @(posedge clk) #1;
        chk("level", carrier_level_reduction, 2'h3);
        foreach (mod_rows[r]) begin
            {internal_envelope, external_signal_input} = mod_rows[r][2:1];
            wr(8'h2A, mod_rows[r][10:3]);
            repeat (6) @(posedge clk) #1;
            chk("modulation", modulation_on, mod_rows[r][0]);
        end
        foreach (drv_rows[r]) begin
            wr(8'h28, drv_rows[r]);
            repeat (3) @(posedge clk) #1;
            chk("oe_a", antenna_out_a_oe, drv_rows[r][3]);
            chk("oe_b", antenna_out_b_oe, drv_rows[r][3]);
            if (drv_rows[r][3])
                chk("inv", antenna_out_a ^ antenna_out_b,
                    drv_rows[r][7] ^ drv_rows[r][6]);
        end
        wr(8'h2B, 8'h07);
        wr(8'h2A, 8'h31);
        repeat (2) @(posedge clk) #1;
        chk("os_on", overshoot_pulse, 1'b1);
        foreach (ck_rows[r]) begin
            {k, code, inv, ap, p} = ck_rows[r];
            w = k == 2'h2 ? 16 : k == 2'h1 ? 8 : 5;
            m = 16'hFFFF >> (16 - w);
            wr(8'h2C, {1'b0, code, k, inv, ap});
            clr = 1'b1;
            @(posedge clk) #1;
            clr = 1'b0;
            stall = r % 2;
            send_frame();
            for (int t = 0; t < 100 && !rx_done; t++) @(posedge clk);
            #1;
            chk("frame", rx_bits, ap ? (({24'h0, FRAME} << w)
                | {16'h0, crc_of() ^ (inv ? m : 16'h0)})
                : {24'h0, FRAME});
            chk("count", rx_cnt, ap ? 8 + w : 8);
        end
        results();
    end
endmodule // tb_top
`default_nettype wire
